// ===== hde_pkg.sv
/*
  Package for the HDLC DMA interrupt enable block: register offsets, enable and
  status bit positions, reset values and the carrier structs of the host port and the event pulses.
  Assumes one system clock shared by the host register port and the event sources.
*/
package hde_pkg;

  localparam int unsigned ADDR_W = 11;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_Q = 5;
  localparam int unsigned Q_CNT_W = 8;

  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFF_MASTER_RESET = 11'h000;
  localparam logic [ADDR_W-1:0] OFF_INT_ENABLE = 11'h004;
  localparam logic [ADDR_W-1:0] OFF_INT_STATUS = 11'h008;

  // Software reset bit of the master reset register
  localparam int unsigned BIT_SOFT_RESET = 15;
  localparam logic RST_SOFT_RESET = 1'b0;

  // Enable / status bit positions, shared by both registers
  localparam int unsigned BIT_SYS_ERR = 0;
  localparam int unsigned BIT_PARITY_ERR = 1;
  localparam int unsigned BIT_RX_CHECKSUM_ERR = 2;
  localparam int unsigned BIT_RX_ABORT = 3;
  localparam int unsigned BIT_RX_FORMAT_ERR = 4;
  localparam int unsigned BIT_RX_OVERRUN = 5;
  localparam int unsigned BIT_RX_SMALL_FREE_READ = 6;
  localparam int unsigned BIT_RX_LARGE_FREE_READ = 7;
  localparam int unsigned BIT_RX_READY_WRITE = 8;
  localparam int unsigned BIT_RX_FREE_EMPTY_ERR = 9;
  localparam int unsigned BIT_RX_READY_FULL_ERR = 10;
  localparam int unsigned BIT_TX_FREE_WRITE = 11;
  localparam int unsigned BIT_TX_READY_READ = 12;
  localparam int unsigned BIT_TX_FREE_FULL_ERR = 13;
  localparam int unsigned BIT_TX_COMPLETE = 14;
  localparam int unsigned BIT_TX_UNDERFLOW = 15;
  localparam int unsigned INT_W = 16;

  localparam logic [INT_W-1:0] RST_INT_ENABLE = 16'h0000;
  localparam logic [INT_W-1:0] RST_INT_STATUS = 16'h0000;

  // Index of each counted descriptor queue access
  localparam int unsigned Q_RX_SMALL_FREE = 0;
  localparam int unsigned Q_RX_LARGE_FREE = 1;
  localparam int unsigned Q_RX_READY = 2;
  localparam int unsigned Q_TX_FREE = 3;
  localparam int unsigned Q_TX_READY = 4;

  // Host register request, one cycle per access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [3:0] byte_en_n;
    logic [DATA_W-1:0] wdata;
  } hde_req_t;

  // Single-cycle event pulses from the frame engine
  typedef struct packed {
    logic rx_checksum_err;
    logic rx_abort;
    logic rx_format_err;
    logic rx_overrun;
    logic rx_free_empty_err;
    logic rx_ready_full_err;
    logic tx_free_full_err;
    logic tx_done;
    logic completion_notify_tag;
    logic tx_underflow;
  } hde_evt_t;

endpackage

// ===== hde_thresh_cnt.sv
/*
  Counts descriptor reference accesses to one queue and pulses once the
  programmed count has been reached. Assumes accesses are one-cycle pulses on clk.
*/
`timescale 1ns/1ps
module hde_thresh_cnt #(
  parameter int unsigned CW = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clear,
  input wire logic access,
  input wire logic [CW-1:0] thresh,
  output logic hit
);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic hit_r;
  logic reached;

  if (CW < 2 || CW > 16) begin : g_bad_width
    $error("hde_thresh_cnt: CW must lie between 2 and 16");
  end

  // A zero threshold disables the count entirely
  assign cnt_nxt = cnt_r + {{(CW-1){1'b0}}, 1'b1};
  assign reached = access && (thresh != '0) && (cnt_nxt >= thresh);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (clear) begin
      cnt_r <= '0;
    end else if (reached) begin
      cnt_r <= '0;
    end else if (access && thresh != '0) begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hit_r <= 1'b0;
    end else begin
      hit_r <= reached && !clear;
    end
  end

  assign hit = hit_r;

endmodule // hde_thresh_cnt

// ===== hde_int_ctrl.sv
/*
  Interrupt enable, status and host interrupt output of an HDLC DMA frame engine.
  Holds the master reset, interrupt enable and interrupt status registers behind
  the host register port. Assumes the host port and all event pulses are
  synchronous to clk; event pulses last one cycle per event.
*/
`timescale 1ns/1ps
module hde_int_ctrl #(
  parameter int unsigned Q_CNT_W = hde_pkg::Q_CNT_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire hde_pkg::hde_req_t req,
  output logic [hde_pkg::DATA_W-1:0] rd_data,
  output logic rd_valid,
  input wire hde_pkg::hde_evt_t evt,
  input wire logic [hde_pkg::NUM_Q-1:0] q_access,
  input wire logic [hde_pkg::NUM_Q-1:0][Q_CNT_W-1:0] q_thresh,
  output logic soft_reset_out,
  output logic host_interrupt_out
);

  localparam int unsigned INT_W = hde_pkg::INT_W;
  localparam int unsigned DATA_W = hde_pkg::DATA_W;

  if (Q_CNT_W < 2 || Q_CNT_W > 16) begin : g_bad_cnt
    $error("hde_int_ctrl: Q_CNT_W must lie between 2 and 16");
  end

  logic soft_reset_r;
  logic [INT_W-1:0] enable_r;
  logic [INT_W-1:0] status_r;
  logic [INT_W-1:0] status_nxt;
  logic [INT_W-1:0] set_vec;
  logic [hde_pkg::NUM_Q-1:0] q_hit;
  logic [DATA_W-1:0] rd_data_r;
  logic [DATA_W-1:0] rd_data_nxt;
  logic rd_valid_r;
  logic irq_r;
  logic access_ok;
  logic wr_reset;
  logic wr_enable;
  logic rd_status;

  // Any access with every byte enable negated touches no register; a read still gets rd_valid with zero data
  assign access_ok = (req.byte_en_n != 4'hf);
  assign wr_reset = req.wr && access_ok && (req.addr == hde_pkg::OFF_MASTER_RESET);
  assign wr_enable = req.wr && access_ok && (req.addr == hde_pkg::OFF_INT_ENABLE);
  assign rd_status = req.rd && access_ok && (req.addr == hde_pkg::OFF_INT_STATUS);

  // Software reset: a write of 0 or the hardware reset clears it, it is not self clearing
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      soft_reset_r <= hde_pkg::RST_SOFT_RESET;
    end else if (wr_reset) begin
      soft_reset_r <= req.wdata[hde_pkg::BIT_SOFT_RESET];
    end
  end

  // Enable register; byte lanes are not split, a write replaces all bits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      enable_r <= hde_pkg::RST_INT_ENABLE;
    end else if (soft_reset_r) begin
      enable_r <= hde_pkg::RST_INT_ENABLE;
    end else if (wr_enable) begin
      enable_r <= req.wdata[INT_W-1:0];
    end
  end

  // Descriptor queue access counters, one per counted queue
  for (genvar q = 0; q < hde_pkg::NUM_Q; q++) begin : g_q
    hde_thresh_cnt #(
      .CW(Q_CNT_W)
    ) u_cnt (
      .clk(clk),
      .rstn(rstn),
      .clear(soft_reset_r),
      .access(q_access[q]),
      .thresh(q_thresh[q]),
      .hit(q_hit[q])
    );
  end

  // Event to status bit mapping; the two PCI error bits have no source here
  always_comb begin
    set_vec = '0;
    set_vec[hde_pkg::BIT_RX_CHECKSUM_ERR] = evt.rx_checksum_err;
    set_vec[hde_pkg::BIT_RX_ABORT] = evt.rx_abort;
    set_vec[hde_pkg::BIT_RX_FORMAT_ERR] = evt.rx_format_err;
    set_vec[hde_pkg::BIT_RX_OVERRUN] = evt.rx_overrun;
    set_vec[hde_pkg::BIT_RX_SMALL_FREE_READ] = q_hit[hde_pkg::Q_RX_SMALL_FREE];
    set_vec[hde_pkg::BIT_RX_LARGE_FREE_READ] = q_hit[hde_pkg::Q_RX_LARGE_FREE];
    set_vec[hde_pkg::BIT_RX_READY_WRITE] = q_hit[hde_pkg::Q_RX_READY];
    set_vec[hde_pkg::BIT_RX_FREE_EMPTY_ERR] = evt.rx_free_empty_err;
    set_vec[hde_pkg::BIT_RX_READY_FULL_ERR] = evt.rx_ready_full_err;
    set_vec[hde_pkg::BIT_TX_FREE_WRITE] = q_hit[hde_pkg::Q_TX_FREE];
    set_vec[hde_pkg::BIT_TX_READY_READ] = q_hit[hde_pkg::Q_TX_READY];
    set_vec[hde_pkg::BIT_TX_FREE_FULL_ERR] = evt.tx_free_full_err;
    set_vec[hde_pkg::BIT_TX_COMPLETE] = evt.tx_done && evt.completion_notify_tag;
    set_vec[hde_pkg::BIT_TX_UNDERFLOW] = evt.tx_underflow;
  end

  // Status latches regardless of enable; a new event beats the read clear
  always_comb begin
    status_nxt = rd_status ? hde_pkg::RST_INT_STATUS : status_r;
    status_nxt = status_nxt | set_vec;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_r <= hde_pkg::RST_INT_STATUS;
    end else if (soft_reset_r) begin
      status_r <= hde_pkg::RST_INT_STATUS;
    end else begin
      status_r <= status_nxt;
    end
  end

  // Read data returns the value before the clear; unmapped offsets read zero
  always_comb begin
    rd_data_nxt = '0;
    if (req.rd && access_ok) begin
      unique case (req.addr)
        hde_pkg::OFF_MASTER_RESET: rd_data_nxt[hde_pkg::BIT_SOFT_RESET] = soft_reset_r;
        hde_pkg::OFF_INT_ENABLE: rd_data_nxt[INT_W-1:0] = enable_r;
        hde_pkg::OFF_INT_STATUS: rd_data_nxt[INT_W-1:0] = status_r;
        default: rd_data_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_r <= '0;
      rd_valid_r <= 1'b0;
    end else begin
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= req.rd;
    end
  end

  // Interrupt from the registered state, so it is glitch free toward the host
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_r & enable_r);
    end
  end

  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;
  assign soft_reset_out = soft_reset_r;
  assign host_interrupt_out = irq_r;

endmodule // hde_int_ctrl

// ===== hde_host.sv
/*
  Host processor model: issues register reads and writes on the request port.
  Assumes the block takes a request at the first edge it is seen.
*/
`timescale 1ns/1ps
module hde_host (
  input wire logic clk,
  output hde_pkg::hde_req_t req
);
  initial req = '0;
  // One access per call; status reads both identify and clear events
  task automatic acc(logic w, logic r, logic [10:0] a, logic [3:0] be, logic [31:0] d);
    @(posedge clk);
    req <= '{wr: w, rd: r, addr: a, byte_en_n: be, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    // Released lines flip so stale values never look valid
    req.addr <= ~a;
    req.wdata <= ~d;
  endtask
endmodule // hde_host

// ===== hde_int_ctrl_monitor.sv
/*
  Checker for the interrupt block, bound to its ports.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module hde_int_ctrl_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire hde_pkg::hde_req_t req,
  input wire logic [hde_pkg::DATA_W-1:0] rd_data,
  input wire logic rd_valid,
  input wire hde_pkg::hde_evt_t evt,
  input wire logic [hde_pkg::NUM_Q-1:0] q_access,
  input wire logic soft_reset_out,
  input wire logic host_interrupt_out
);
  logic [15:0] en_r;
  logic [15:0] ev;
  logic be_ok;
  assign be_ok = req.byte_en_n != 4'hf;
  assign ev = {evt.tx_underflow, evt.tx_done & evt.completion_notify_tag, evt.tx_free_full_err,
    2'b00, evt.rx_ready_full_err, evt.rx_free_empty_err, 3'b000, evt.rx_overrun,
    evt.rx_format_err, evt.rx_abort, evt.rx_checksum_err, 2'b00};
  // Shadow of the enable register; soft reset wins over a write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) en_r <= '0;
    else if (soft_reset_out) en_r <= '0;
    else if (req.wr && be_ok && req.addr == hde_pkg::OFF_INT_ENABLE) en_r <= req.wdata[15:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_status_rd;
    req.rd && be_ok && req.addr == hde_pkg::OFF_INT_STATUS;
  endsequence
  // Queue hits lag one cycle, so the access before also has to be quiet
  sequence s_quiet;
    evt == '0 && q_access == '0 && $past(q_access) == '0;
  endsequence
  property p_rd_clears; (s_status_rd and s_quiet) |-> ##2 !host_interrupt_out; endproperty
  property p_evt_irq;
    !soft_reset_out && !req.wr && (ev & en_r) != '0 |-> ##2 host_interrupt_out;
  endproperty
  property p_mask; en_r == '0 |=> !host_interrupt_out; endproperty
  property p_rd_valid; req.rd |=> rd_valid && rd_data[31:16] == '0; endproperty
  property p_no_rd; !req.rd |=> !rd_valid && rd_data == '0; endproperty
  property p_refused; req.rd && !be_ok |=> rd_data == '0; endproperty
  property p_en_read;
    req.rd && be_ok && req.addr == hde_pkg::OFF_INT_ENABLE |=> rd_data == {16'h0000, en_r};
  endproperty
  property p_soft_hold;
    soft_reset_out && !(req.wr && be_ok && req.addr == hde_pkg::OFF_MASTER_RESET)
      |=> soft_reset_out;
  endproperty
  property p_reset_idle;
    $rose(rstn) |-> !host_interrupt_out && !rd_valid && !soft_reset_out;
  endproperty
  a_rd_clears: assert property (p_rd_clears) else $error("irq after status read");
  a_evt_irq: assert property (p_evt_irq) else $error("irq missing");
  a_mask: assert property (p_mask) else $error("irq while masked");
  a_rd_valid: assert property (p_rd_valid) else $error("read answer bad");
  a_no_rd: assert property (p_no_rd) else $error("stray read data");
  a_refused: assert property (p_refused) else $error("no-access read data");
  a_en_read: assert property (p_en_read) else $error("enable readback");
  a_soft_hold: assert property (p_soft_hold) else $error("soft reset dropped");
  a_reset_idle: assert property (p_reset_idle) else $error("outputs after reset");
endmodule // hde_int_ctrl_monitor
bind hde_int_ctrl hde_int_ctrl_monitor hde_int_ctrl_monitor_i (.clk(clk), .rstn(rstn),
  .req(req), .rd_data(rd_data), .rd_valid(rd_valid), .evt(evt), .q_access(q_access),
  .soft_reset_out(soft_reset_out), .host_interrupt_out(host_interrupt_out));

// ===== hde_int_ctrl_bench.sv
/*
  Self-checking bench for the interrupt block with a host model.
  Assumes the checker is bound in by its own file.
*/
`timescale 1ns/1ps
module hde_int_ctrl_bench;
  logic clk, rstn, rd_valid, soft_reset_out, host_interrupt_out;
  hde_pkg::hde_req_t req;
  hde_pkg::hde_evt_t evt;
  logic [hde_pkg::DATA_W-1:0] rd_data;
  logic [hde_pkg::NUM_Q-1:0] q_access;
  logic [hde_pkg::NUM_Q-1:0][7:0] q_thresh;
  logic [31:0] exp_q[$];
  logic [31:0] w;
  int err_count, checks_done, n;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  hde_host hde_host_i (.clk(clk), .req(req));
  hde_int_ctrl hde_int_ctrl_i (.clk(clk), .rstn(rstn), .req(req), .rd_data(rd_data),
    .rd_valid(rd_valid), .evt(evt), .q_access(q_access), .q_thresh(q_thresh),
    .soft_reset_out(soft_reset_out), .host_interrupt_out(host_interrupt_out));
  function automatic int qi(int b);
    return (b < 9) ? b - 6 : b - 8;
  endfunction
  task automatic chk(string what, logic [31:0] e, logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic rd(logic [10:0] a, logic [31:0] e);
    exp_q.push_back(e);
    hde_host_i.acc(1'b0, 1'b1, a, 4'h0, 32'h0);
  endtask
  task automatic wr(logic [10:0] a, logic [3:0] be, logic [31:0] d);
    hde_host_i.acc(1'b1, 1'b0, a, be, d);
  endtask
  task automatic chk_irq(logic e);
    repeat (3) @(posedge clk);
    #1;
    chk("irq", {31'h0, e}, {31'h0, host_interrupt_out});
  endtask
  task automatic pulse(int b);
    @(posedge clk);
    case (b)
      2: evt.rx_checksum_err <= 1'b1;
      3: evt.rx_abort <= 1'b1;
      4: evt.rx_format_err <= 1'b1;
      5: evt.rx_overrun <= 1'b1;
      9: evt.rx_free_empty_err <= 1'b1;
      10: evt.rx_ready_full_err <= 1'b1;
      13: evt.tx_free_full_err <= 1'b1;
      14: evt <= '{tx_done: 1'b1, completion_notify_tag: 1'b1, default: 1'b0};
      15: evt.tx_underflow <= 1'b1;
      16: evt.tx_done <= 1'b1;
      default: q_access[qi(b)] <= 1'b1;
    endcase
    @(posedge clk);
    evt <= '0;
    q_access <= '0;
  endtask
  task automatic complete_run();
    if (err_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Read answers are matched in order of issue
  always @(posedge clk) if (rd_valid === 1'b1) chk("rd_data", exp_q.pop_front(), rd_data);
  initial begin
    #100000;
    err_count++;
    complete_run();
  end
  initial begin
    rstn = 1'b0;
    evt = '0;
    q_access = '0;
    q_thresh = '0;
    void'($urandom(62));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++) q_thresh[i] <= 8'($urandom_range(3, 1));
    rd(hde_pkg::OFF_INT_ENABLE, 32'h0);
    rd(11'h00c, 32'h0);
    w = $urandom();
    wr(hde_pkg::OFF_INT_ENABLE, 4'($urandom_range(14, 0)), w);
    wr(hde_pkg::OFF_INT_ENABLE, 4'hf, ~w);
    rd(hde_pkg::OFF_INT_ENABLE, {16'h0, w[15:0]});
    for (int b = 2; b < 16; b++) begin
      n = (b inside {6, 7, 8, 11, 12}) ? int'(q_thresh[qi(b)]) : 1;
      wr(hde_pkg::OFF_INT_ENABLE, 4'h0, 32'h1 << b);
      repeat (n - 1) pulse(b);
      rd(hde_pkg::OFF_INT_STATUS, 32'h0);
      pulse(b);
      chk_irq(1'b1);
      rd(hde_pkg::OFF_INT_STATUS, 32'h1 << b);
      chk_irq(1'b0);
      wr(hde_pkg::OFF_INT_ENABLE, 4'h0, ~(32'h1 << b));
      repeat (n) pulse(b);
      chk_irq(1'b0);
      rd(hde_pkg::OFF_INT_STATUS, 32'h1 << b);
    end
    // Completion without the notify tag must not set the status bit
    pulse(16);
    rd(hde_pkg::OFF_INT_STATUS, 32'h0);
    pulse(2);
    exp_q.push_back(32'h0);
    hde_host_i.acc(1'b0, 1'b1, hde_pkg::OFF_INT_STATUS, 4'hf, 32'h0);
    chk_irq(1'b1);
    rd(hde_pkg::OFF_INT_STATUS, 32'h4);
    pulse(3);
    wr(hde_pkg::OFF_MASTER_RESET, 4'h0, 32'h8000);
    #1 chk("soft_reset_out", 32'h1, {31'h0, soft_reset_out});
    rd(hde_pkg::OFF_MASTER_RESET, 32'h8000);
    rd(hde_pkg::OFF_INT_ENABLE, 32'h0);
    rd(hde_pkg::OFF_INT_STATUS, 32'h0);
    chk_irq(1'b0);
    wr(hde_pkg::OFF_MASTER_RESET, 4'h0, 32'h0);
    #1 chk("soft_reset_out", 32'h0, {31'h0, soft_reset_out});
    rd(hde_pkg::OFF_MASTER_RESET, 32'h0);
    // Hardware reset in mid-run must mask every source again
    wr(hde_pkg::OFF_INT_ENABLE, 4'h0, 32'hffff);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    rd(hde_pkg::OFF_INT_ENABLE, 32'h0);
    repeat (3) @(posedge clk);
    complete_run();
  end
endmodule // hde_int_ctrl_bench
